/* design/dlm_top.sv */
// diagnostics and sensorless load monitor with an AHB-Lite register slave
// assumes synchronous detector and supply-monitor inputs and a fullstep pulse
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`default_nettype none

module dlm_top
   import dlm_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // temperature and supply monitors
   input wire logic temp_prewarn_det,
   input wire logic temp_shutdown_det,
   input wire logic uv_logic_supply,
   input wire logic uv_driver_supply,
   // motor measurement front end
   input wire logic fullstep_pulse,
   input wire logic [9:0] raw_load_sample,
   // driver controls and pins
   output logic driver_enable,
   output logic [1:0] hs_gate_current,
   output logic [4:0] actual_current_scale,
   output logic stall_output_pin,
   output logic irq
);

   // ==========================================
   // declarations
   dlm_ctrl_t ctrl_q, ctrl_d;
   dlm_diag_t diag_q, diag_d;
   logic [DLM_EV_W-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
   logic wr_pend_q, wr_pend_d;
   logic [7:0] wr_addr_q, wr_addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic drv_en_q, drv_en_d;
   logic [1:0] gate_q, gate_d;
   logic step_odd_q, step_odd_d;
   logic [9:0] prev_raw_q, prev_raw_d;
   logic uv, addr_valid, sample_take;
   logic [9:0] sample_val, avg_val;
   logic avg_valid;
   logic [DLM_EV_W-1:0] events, clr_mask;
   logic [31:0] stat_word, read_mux;

   // ==========================================
   // helpers

   // threshold offset shifts the curve; result clamped to the unsigned span
   function automatic logic [9:0] dlm_scale_load(input logic [9:0] raw, input logic [6:0] thr);
      logic signed [12:0] v;
      v = $signed({3'h0, raw}) + ($signed({{6{thr[6]}}, thr}) * DLM_THR_GAIN);
      if (v < 13'sh0000)
         return 10'h000;
      else if (v > $signed({3'h0, DLM_LOAD_MAX}))
         return DLM_LOAD_MAX;
      else
         return v[9:0];
   endfunction

   function automatic logic dlm_is_tc(input logic [1:0] setting);
      return (setting == DLM_TC_SET_A) || (setting == DLM_TC_SET_B);
   endfunction

   // ==========================================
   // bus decode
   assign uv = uv_logic_supply | uv_driver_supply;
   assign addr_valid = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[DLM_ST_PREWARN] = diag_q.temp_prewarn_flag;
      stat_word[DLM_ST_OVERTEMP] = diag_q.overtemp_shutdown_flag;
      stat_word[DLM_ST_UNDERVOLT] = diag_q.undervolt;
      stat_word[DLM_ST_STALL] = diag_q.stall;
      stat_word[DLM_ST_SCALE_LSB +: 5] = ctrl_q.current_scale;
      stat_word[DLM_ST_LOAD_LSB +: 10] = diag_q.load_measurement_value;
      case (haddr[7:0])
         DLM_CTRL_OFS: read_mux = {15'h0000, ctrl_q};
         DLM_STAT_OFS: read_mux = stat_word;
         DLM_IRQ_STAT_OFS: read_mux = {27'h0000000, irq_stat_q};
         DLM_IRQ_EN_OFS: read_mux = {27'h0000000, irq_en_q};
         default: read_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================
   // bus pipeline and control register
   always_comb begin
      wr_pend_d = addr_valid & hwrite;
      wr_addr_d = haddr[7:0];
      rdata_d = rdata_q;
      if (addr_valid && !hwrite)
         rdata_d = uv ? 32'h0000_0000 : read_mux;
      ctrl_d = ctrl_q;
      irq_en_d = irq_en_q;
      clr_mask = '0;
      if (wr_pend_q && !uv) begin
         case (wr_addr_q)
            DLM_CTRL_OFS: ctrl_d = hwdata[$bits(dlm_ctrl_t)-1:0];
            DLM_IRQ_EN_OFS: irq_en_d = hwdata[DLM_EV_W-1:0];
            DLM_IRQ_CLR_OFS: clr_mask = hwdata[DLM_EV_W-1:0];
            default: ctrl_d = ctrl_q;
         endcase
      end
      // undervoltage resets the control logic and zeroes the scale
      if (uv)
         ctrl_d = DLM_CTRL_RST;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
         ctrl_q <= DLM_CTRL_RST;
         irq_en_q <= DLM_IRQ_RST;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         irq_en_q <= irq_en_d;
      end
   end

   // ==========================================
   // temperature, supply and driver stage
   always_comb begin
      diag_d = diag_q;
      diag_d.temp_prewarn_flag = temp_prewarn_det;
      diag_d.undervolt = uv;
      // latched until cool and the enable has been dropped
      if (temp_shutdown_det)
         diag_d.overtemp_shutdown_flag = 1'b1;
      else if (!ctrl_q.driver_enable)
         diag_d.overtemp_shutdown_flag = 1'b0;
      if (avg_valid) begin
         diag_d.load_measurement_value = avg_val;
         diag_d.stall = (avg_val == 10'h000);
      end
      drv_en_d = ctrl_q.driver_enable & ~diag_d.overtemp_shutdown_flag & ~uv;
      gate_d = ctrl_q.gate_setting;
      // p-channel drive weakens when hot; only the two marked codes, which never wrap
      if (diag_q.temp_prewarn_flag && dlm_is_tc(ctrl_q.gate_setting))
         gate_d = ctrl_q.gate_setting + 2'h1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diag_q <= DLM_DIAG_RST;
         drv_en_q <= 1'b0;
         gate_q <= 2'h0;
      end else begin
         diag_q <= diag_d;
         drv_en_q <= drv_en_d;
         gate_q <= gate_d;
      end
   end

   assign driver_enable = drv_en_q;
   assign hs_gate_current = gate_q;
   assign actual_current_scale = ctrl_q.current_scale;
   assign stall_output_pin = diag_q.stall;

   // ==========================================
   // load measurement, one sample per two fullsteps
   assign sample_take = fullstep_pulse & step_odd_q;

   always_comb begin
      step_odd_d = step_odd_q;
      prev_raw_d = prev_raw_q;
      if (fullstep_pulse)
         step_odd_d = ~step_odd_q;
      if (sample_take)
         prev_raw_d = raw_load_sample;
      // low-velocity mode smooths across consecutive samples at the cost of lag
      if (ctrl_q.low_speed_filter_select)
         sample_val = dlm_scale_load(10'(({1'b0, raw_load_sample} + {1'b0, prev_raw_q}) >> 1),
                                     ctrl_q.load_threshold_offset);
      else
         sample_val = dlm_scale_load(raw_load_sample, ctrl_q.load_threshold_offset);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_odd_q <= 1'b0;
         prev_raw_q <= 10'h000;
      end else begin
         step_odd_q <= step_odd_d;
         prev_raw_q <= prev_raw_d;
      end
   end

   dlm_load_avg u_avg (
      .hclk(hclk),
      .hresetn(hresetn),
      .sample_valid(sample_take),
      .sample(sample_val),
      .avg_enable(ctrl_q.load_filter_enable),
      .result_valid(avg_valid),
      .result(avg_val)
   );

   // ==========================================
   // interrupts: sticky status, set wins over clear
   always_comb begin
      events = '0;
      events[DLM_EV_PREWARN] = diag_d.temp_prewarn_flag & ~diag_q.temp_prewarn_flag;
      events[DLM_EV_OVERTEMP] = diag_d.overtemp_shutdown_flag & ~diag_q.overtemp_shutdown_flag;
      events[DLM_EV_UNDERVOLT] = uv & ~diag_q.undervolt;
      events[DLM_EV_STALL] = diag_d.stall & ~diag_q.stall;
      events[DLM_EV_MEASURE] = avg_valid;
      irq_stat_d = (irq_stat_q & ~clr_mask) | events;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq_stat_q <= DLM_IRQ_RST;
      else
         irq_stat_q <= irq_stat_d;
   end

   assign irq = |(irq_stat_q & irq_en_q);

   // ==========================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   prewarn_flag_a: assert property (
      1'b1 |=> diag_q.temp_prewarn_flag == $past(temp_prewarn_det))
      else $error("prewarn flag did not follow detector");

   prewarn_event_a: assert property (
      temp_prewarn_det && !diag_q.temp_prewarn_flag |=> irq_stat_q[DLM_EV_PREWARN])
      else $error("prewarn rise not recorded in status");

   ot_gate_a: assert property (
      diag_q.overtemp_shutdown_flag |-> !driver_enable)
      else $error("driver on while shutdown flag set");

   ot_driver_off_a: assert property (
      temp_shutdown_det |=> diag_q.overtemp_shutdown_flag && !driver_enable)
      else $error("driver still on after shutdown threshold");

   gate_boost_a: assert property (
      diag_q.temp_prewarn_flag && dlm_is_tc(ctrl_q.gate_setting) && $stable(ctrl_q)
      |=> hs_gate_current == $past(ctrl_q.gate_setting) + 2'h1)
      else $error("compensated gate current not raised");

   gate_plain_a: assert property (
      !(diag_q.temp_prewarn_flag && dlm_is_tc(ctrl_q.gate_setting)) && $stable(ctrl_q)
      |=> hs_gate_current == $past(ctrl_q.gate_setting))
      else $error("gate current raised outside compensation");

   uv_driver_off_a: assert property (
      uv |=> !driver_enable && !ctrl_q.driver_enable)
      else $error("driver enabled during undervoltage");

   uv_ctrl_rst_a: assert property (
      uv |=> ctrl_q == DLM_CTRL_RST)
      else $error("control not reset by undervoltage");

   uv_flag_a: assert property (
      1'b1 |=> diag_q.undervolt == $past(uv))
      else $error("undervoltage flag did not follow monitors");

   uv_silent_a: assert property (
      addr_valid && !hwrite && uv |=> hrdata == 32'h0000_0000)
      else $error("read data not zero during undervoltage");

   uv_scale_zero_a: assert property (
      uv |=> actual_current_scale == 5'h00)
      else $error("current scale not cleared by undervoltage");

   load_rate_a: assert property (
      fullstep_pulse && !step_odd_q |=> !avg_valid ##1 !avg_valid)
      else $error("load result issued on odd fullstep");

   measure_irq_a: assert property (
      avg_valid |=> irq_stat_q[DLM_EV_MEASURE])
      else $error("new load value not recorded in status");

   measure_clr_a: assert property (
      irq_stat_q[DLM_EV_MEASURE] && clr_mask[DLM_EV_MEASURE] && !avg_valid
      |=> !irq_stat_q[DLM_EV_MEASURE])
      else $error("measure status not cleared");

   stall_sticky_a: assert property (
      irq_stat_q[DLM_EV_STALL] && !clr_mask[DLM_EV_STALL] |=> irq_stat_q[DLM_EV_STALL])
      else $error("stall status lost without clear");

   stall_pin_a: assert property (
      avg_valid |=> stall_output_pin == ($past(avg_val) == 10'h000))
      else $error("stall pin does not match zero load value");

   load_capture_a: assert property (
      avg_valid |=> diag_q.load_measurement_value == $past(avg_val))
      else $error("load value not captured");

   load_hold_a: assert property (
      !avg_valid |=> $stable(diag_q.load_measurement_value))
      else $error("load value changed without result");

   rdata_hold_a: assert property (
      !(addr_valid && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without read");

   ot_hold_a: assert property (
      diag_q.overtemp_shutdown_flag && ctrl_q.driver_enable |=> diag_q.overtemp_shutdown_flag)
      else $error("shutdown flag cleared while driver enabled");

   ot_release_a: assert property (
      !temp_shutdown_det && !ctrl_q.driver_enable |=> !diag_q.overtemp_shutdown_flag)
      else $error("shutdown flag kept after cool and disabled");

endmodule
`default_nettype wire

/* design/dlm_pkg.sv */
// package of the driver diagnostics and load monitor: register map, fields, types
// assumes a single 10 MHz clock and an AHB-Lite register bus
`default_nettype none
package dlm_pkg;

   // ==========================================
   // register byte addresses
   localparam logic [7:0] DLM_CTRL_OFS = 8'h00;
   localparam logic [7:0] DLM_STAT_OFS = 8'h04;
   localparam logic [7:0] DLM_IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] DLM_IRQ_EN_OFS = 8'h0C;
   localparam logic [7:0] DLM_IRQ_CLR_OFS = 8'h10;

   // ==========================================
   // status word field positions
   localparam int DLM_ST_PREWARN = 0;
   localparam int DLM_ST_OVERTEMP = 1;
   localparam int DLM_ST_UNDERVOLT = 2;
   localparam int DLM_ST_STALL = 3;
   localparam int DLM_ST_SCALE_LSB = 8;
   localparam int DLM_ST_LOAD_LSB = 16;

   // ==========================================
   // interrupt event bit positions
   localparam int DLM_EV_PREWARN = 0;
   localparam int DLM_EV_OVERTEMP = 1;
   localparam int DLM_EV_UNDERVOLT = 2;
   localparam int DLM_EV_STALL = 3;
   localparam int DLM_EV_MEASURE = 4;
   localparam int DLM_EV_W = 5;

   // ==========================================
   // load measurement, gate compensation and interrupt reset constants
   localparam logic [9:0] DLM_LOAD_MAX = 10'h3FF;
   localparam logic [9:0] DLM_LOAD_RST = 10'h3FF;
   localparam logic signed [12:0] DLM_THR_GAIN = 13'sh0010;
   localparam logic [1:0] DLM_AVG_COUNT = 2'h3;
   localparam logic [1:0] DLM_TC_SET_A = 2'h1;
   localparam logic [1:0] DLM_TC_SET_B = 2'h2;
   localparam logic [DLM_EV_W-1:0] DLM_IRQ_RST = 5'h00;

   // ==========================================
   // control register layout, listed from the top bit down, last field at bit 0
   typedef struct packed {
      logic [6:0] load_threshold_offset;
      logic [4:0] current_scale;
      logic [1:0] gate_setting;
      logic low_speed_filter_select;
      logic load_filter_enable;
      logic driver_enable;
   } dlm_ctrl_t;

   localparam dlm_ctrl_t DLM_CTRL_RST = '0;

   // ==========================================
   // captured diagnostics
   typedef struct packed {
      logic [9:0] load_measurement_value;
      logic stall;
      logic undervolt;
      logic overtemp_shutdown_flag;
      logic temp_prewarn_flag;
   } dlm_diag_t;

   localparam dlm_diag_t DLM_DIAG_RST = '{DLM_LOAD_RST, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage
`default_nettype wire

/* design/dlm_load_avg.sv */
// three-sample block average of load results, or pass-through when disabled
// assumes sample_valid pulses at most once per cycle
`default_nettype none
module dlm_load_avg
   import dlm_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // samples in
   input wire logic sample_valid,
   input wire logic [9:0] sample,
   input wire logic avg_enable,
   // result out
   output logic result_valid,
   output logic [9:0] result
);

   typedef enum logic [1:0] {DLM_AVG_FIRST, DLM_AVG_SECOND, DLM_AVG_THIRD} dlm_avg_t;

   dlm_avg_t phase_q, phase_d;
   logic [11:0] acc_q, acc_d;
   logic [9:0] res_q, res_d;
   logic valid_q, valid_d;
   logic [11:0] sum;

   // ==========================================
   // next state
   always_comb begin
      phase_d = phase_q;
      acc_d = acc_q;
      res_d = res_q;
      valid_d = 1'b0;
      sum = acc_q + {2'h0, sample};
      if (sample_valid) begin
         if (!avg_enable) begin
            res_d = sample;
            valid_d = 1'b1;
            phase_d = DLM_AVG_FIRST;
            acc_d = 12'h000;
         end else begin
            case (phase_q)
               DLM_AVG_FIRST: begin
                  acc_d = {2'h0, sample};
                  phase_d = DLM_AVG_SECOND;
               end
               DLM_AVG_SECOND: begin
                  acc_d = sum;
                  phase_d = DLM_AVG_THIRD;
               end
               DLM_AVG_THIRD: begin
                  // one result per three samples, i.e. six fullsteps
                  res_d = 10'(sum / {10'h000, DLM_AVG_COUNT});
                  valid_d = 1'b1;
                  acc_d = 12'h000;
                  phase_d = DLM_AVG_FIRST;
               end
               default: phase_d = DLM_AVG_FIRST;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q <= DLM_AVG_FIRST;
         acc_q <= 12'h000;
         res_q <= DLM_LOAD_RST;
         valid_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         acc_q <= acc_d;
         res_q <= res_d;
         valid_q <= valid_d;
      end
   end

   assign result_valid = valid_q;
   assign result = res_q;

   // ==========================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   avg_rate_a: assert property (
      sample_valid && avg_enable && phase_q != DLM_AVG_THIRD |=> !result_valid)
      else $error("filtered result issued before third sample");

endmodule
`default_nettype wire

/* verif/dlm_motor_model.sv */
// motor front end model: fullstep pulses and raw load samples
// assumes the bench calls step_pair after a rising edge of hclk
`default_nettype none
module dlm_motor_model (
   // clock
   input wire logic hclk,
   // front end outputs
   output logic fullstep_pulse,
   output logic [9:0] raw_load_sample
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // stepping
   initial begin
      fullstep_pulse = 1'b0;
      raw_load_sample = 10'h000;
   end

   // raw held across both pulses, so the sampling phase does not matter
   // loaded and unloaded raws used by the bench differ by 90 or more
   task automatic step_pair(input logic [9:0] raw);
      repeat (2) begin
         @(posedge hclk);
         fullstep_pulse <= 1'b1;
         raw_load_sample <= raw;
         @(posedge hclk);
         fullstep_pulse <= 1'b0;
      end
      repeat (3) @(posedge hclk);
   endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench of the diagnostics and load monitor
// assumes one 10 MHz clock; hready is fed back from hreadyout
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dlm_pkg::*;

   // ==========================================
   // signals
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, hs_gate_current;
   logic [2:0] hsize;
   logic temp_prewarn_det, temp_shutdown_det, uv_logic_supply, uv_driver_supply;
   logic fullstep_pulse, driver_enable, stall_output_pin;
   logic [9:0] raw_load_sample;
   logic [4:0] actual_current_scale;
   int error_cnt = 0;
   int n_compared = 0;

   always #50 hclk = ~hclk;

   dlm_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .temp_prewarn_det(temp_prewarn_det), .temp_shutdown_det(temp_shutdown_det),
      .uv_logic_supply(uv_logic_supply), .uv_driver_supply(uv_driver_supply),
      .fullstep_pulse(fullstep_pulse), .raw_load_sample(raw_load_sample),
      .driver_enable(driver_enable), .hs_gate_current(hs_gate_current),
      .actual_current_scale(actual_current_scale), .stall_output_pin(stall_output_pin),
      .irq(irq));

   dlm_motor_model u_motor (.hclk(hclk), .fullstep_pulse(fullstep_pulse),
      .raw_load_sample(raw_load_sample));

   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // single transfer; only the watchdog ends a real hang
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      ahb(1'b0, a, 32'h00000000);
      chk(rd & m, e);
   endtask

   function automatic logic [31:0] ctrl(input logic [6:0] thr, input logic [4:0] sc,
      input logic [1:0] g, input logic filt, input logic en);
      return {15'h0000, thr, sc, g, 1'b0, filt, en};
   endfunction

   task automatic final_report();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ==========================================
   // tests
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, temp_prewarn_det, temp_shutdown_det} = 4'h0;
      {uv_logic_supply, uv_driver_supply} = 2'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      cyc(16);
      hresetn <= 1'b1;
      cyc(1);
      rdc(DLM_CTRL_OFS, 32'hFFFFFFFF, 32'h00000000);
      rdc(DLM_STAT_OFS, 32'hFFFFFFFF, 32'h03FF0000);
      rdc(8'h14, 32'hFFFFFFFF, 32'h00000000);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      // a transfer without select must leave the control word alone
      haddr <= 32'h00000000;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      cyc(1);
      htrans <= 2'h0;
      hwdata <= 32'h0001FFFF;
      cyc(1);
      rdc(DLM_CTRL_OFS, 32'hFFFFFFFF, 32'h00000000);
      // only the two compensated codes step up while warm
      for (int g = 0; g < 4; g++) begin
         for (int p = 0; p < 2; p++) begin
            temp_prewarn_det <= p[0];
            wr(DLM_CTRL_OFS, ctrl(7'h00, 5'h15, g[1:0], 1'b0, 1'b1));
            cyc(3);
            chk({30'h0, hs_gate_current}, g + ((p == 1 && (g == 1 || g == 2)) ? 1 : 0));
         end
      end
      rdc(DLM_STAT_OFS, 32'h00001F01, 32'h00001501);
      rdc(DLM_IRQ_STAT_OFS, 32'h00000001, 32'h00000001);
      temp_prewarn_det <= 1'b0;
      chk({31'h0, driver_enable}, 32'h1);
      temp_shutdown_det <= 1'b1;
      cyc(3);
      chk({31'h0, driver_enable}, 32'h0);
      temp_shutdown_det <= 1'b0;
      cyc(2);
      rdc(DLM_STAT_OFS, 32'h00000002, 32'h00000002);
      wr(DLM_CTRL_OFS, ctrl(7'h00, 5'h15, 2'h0, 1'b0, 1'b0));
      cyc(2);
      rdc(DLM_STAT_OFS, 32'h00000002, 32'h00000000);
      wr(DLM_CTRL_OFS, ctrl(7'h00, 5'h15, 2'h0, 1'b0, 1'b1));
      cyc(3);
      chk({31'h0, driver_enable}, 32'h1);
      // load value, threshold gain and stall pin
      wr(DLM_IRQ_EN_OFS, 32'h00000008);
      u_motor.step_pair(10'd200);
      rdc(DLM_STAT_OFS, 32'h03FF0008, {6'h00, 10'd200, 16'h0000});
      wr(DLM_CTRL_OFS, ctrl(7'h02, 5'h15, 2'h0, 1'b0, 1'b1));
      u_motor.step_pair(10'd100);
      rdc(DLM_STAT_OFS, 32'h03FF0008, {6'h00, 10'd132, 16'h0000});
      wr(DLM_CTRL_OFS, ctrl(7'h7F, 5'h15, 2'h0, 1'b0, 1'b1));
      u_motor.step_pair(10'd10);
      rdc(DLM_STAT_OFS, 32'h03FF0008, 32'h00000008);
      chk({31'h0, stall_output_pin}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(DLM_IRQ_CLR_OFS, 32'h0000001F);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      rdc(DLM_IRQ_STAT_OFS, 32'h00000008, 32'h00000000);
      // low-velocity mode: halfway between this raw and the previous one (10)
      wr(DLM_CTRL_OFS, ctrl(7'h00, 5'h15, 2'h0, 1'b0, 1'b1) | 32'h00000004);
      u_motor.step_pair(10'd110);
      rdc(DLM_STAT_OFS, 32'h03FF0008, {6'h00, 10'd60, 16'h0000});
      chk({31'h0, stall_output_pin}, 32'h0);
      // either supply low clears control and silences reads
      for (int i = 0; i < 2; i++) begin
         wr(DLM_CTRL_OFS, ctrl(7'h00, 5'h15, 2'h0, 1'b0, 1'b1));
         cyc(3);
         uv_logic_supply <= (i == 0);
         uv_driver_supply <= (i == 1);
         cyc(3);
         chk({27'h0, actual_current_scale}, 32'h0);
         chk({31'h0, driver_enable}, 32'h0);
         rdc(DLM_STAT_OFS, 32'hFFFFFFFF, 32'h00000000);
         wr(DLM_CTRL_OFS, ctrl(7'h00, 5'h15, 2'h0, 1'b0, 1'b1));
         uv_logic_supply <= 1'b0;
         uv_driver_supply <= 1'b0;
         cyc(2);
         rdc(DLM_CTRL_OFS, 32'hFFFFFFFF, 32'h00000000);
      end
      // filtered mode from a fresh reset so the sample phase is known
      hresetn <= 1'b0;
      cyc(2);
      hresetn <= 1'b1;
      cyc(1);
      wr(DLM_CTRL_OFS, ctrl(7'h00, 5'h00, 2'h0, 1'b1, 1'b1));
      u_motor.step_pair(10'd30);
      u_motor.step_pair(10'd60);
      rdc(DLM_STAT_OFS, 32'h03FF0000, 32'h03FF0000);
      u_motor.step_pair(10'd90);
      rdc(DLM_STAT_OFS, 32'h03FF0000, {6'h00, 10'd60, 16'h0000});
      final_report();
   end

   // ==========================================
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #1000000;
      error_cnt++;
      final_report();
   end
endmodule
`default_nettype wire
